/* File: vio_pkg.sv */
// register map, field values and shared types of the virtual io mapping block
package vio_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W  = 16;
	localparam int IN_N   = 8;
	localparam int OUT_N  = 7;
	localparam int IDX_W  = 10;
	localparam int COND_W = 20;

	// register indices; byte address is four times the index
	localparam logic [IN_N-1:0][IDX_W-1:0] IDX_VIN_FUNC = {
		10'h025, 10'h023, 10'h021, 10'h01F, 10'h01D, 10'h01B, 10'h019, 10'h017};
	localparam logic [IN_N-1:0][IDX_W-1:0] IDX_VIN_MODE = {
		10'h026, 10'h024, 10'h022, 10'h020, 10'h01E, 10'h01C, 10'h01A, 10'h018};
	localparam logic [OUT_N-1:0][IDX_W-1:0] IDX_VOUT_FUNC = {
		10'h038, 10'h036, 10'h034, 10'h032, 10'h030, 10'h02E, 10'h02C};
	localparam logic [OUT_N-1:0][IDX_W-1:0] IDX_VOUT_POL = {
		10'h039, 10'h037, 10'h035, 10'h033, 10'h031, 10'h02F, 10'h02D};
	localparam logic [IDX_W-1:0] IDX_VOUT_LEVEL = 10'h02B;
	localparam logic [IDX_W-1:0] IDX_VIN_VALUE  = 10'h040;

	localparam logic [REG_W-1:0] REG_RESET  = 16'h0000;
	localparam logic [REG_W-1:0] MODE_EDGE  = 16'h0001;
	localparam logic [REG_W-1:0] POL_LOW    = 16'h0001;
	localparam logic [REG_W-1:0] FUNC_NONE  = 16'h0000;
	localparam logic [REG_W-1:0] FUNC_SPARE = 16'h0010;
	localparam logic [REG_W-1:0] FUNC_LAST  = 16'h0013;

	// drive conditions; bit position equals the output function code
	typedef struct packed {
		logic angle_ident_ready;
		logic dynamic_brake;
		logic brake_control;
		logic spare16;
		logic electrical_homing_complete;
		logic homing_complete;
		logic speed_limited;
		logic torque_limited;
		logic positioning_complete;
		logic positioning_near;
		logic torque_reached;
		logic speed_reached;
		logic speed_coincidence;
		logic zero_speed;
		logic motor_rotating;
		logic fault;
		logic warning;
		logic running;
		logic drive_ready;
		logic spare0;
	} vio_cond_s;

	typedef struct packed {
		logic [IN_N-1:0][REG_W-1:0]  in_func;
		logic [IN_N-1:0][REG_W-1:0]  in_mode;
		logic [OUT_N-1:0][REG_W-1:0] out_func;
		logic [OUT_N-1:0][REG_W-1:0] out_pol;
		logic [IN_N-1:0]             vin_value;
		logic [IN_N-1:0]             vin_pulse;
		logic [IN_N-1:0]             vin_active;
		logic [OUT_N-1:0]            vout;
		logic [DATA_W-1:0]           prdata;
		logic                        pready;
		logic                        pslverr;
	} vio_state_s;
endpackage

/* File: vio_top.sv */
// virtual input and output mapping with its apb register file
//
// The APB slave port is this design's own decision.
module vio_top
	import vio_pkg::*;
(
	input  wire logic                        CLOCK,
	input  wire logic                        RST_N,
	input  wire logic                        PSEL,
	input  wire logic                        PENABLE,
	input  wire logic                        PWRITE,
	input  wire logic [ADDR_W-1:0]           PADDR,
	input  wire logic [DATA_W-1:0]           PWDATA,
	output logic      [DATA_W-1:0]           PRDATA,
	output logic                             PREADY,
	output logic                             PSLVERR,
	input  wire vio_cond_s                   DRIVE_COND,
	output logic      [IN_N-1:0]             VIN_ACTIVE,
	output logic      [IN_N-1:0][REG_W-1:0]  VIN_FUNC,
	output logic      [OUT_N-1:0]            VOUT
);
	vio_state_s          st;
	vio_state_s          next_st;
	logic [IDX_W-1:0]    idx;
	logic                hit;
	logic                ro;
	logic [REG_W-1:0]    rd;
	logic                done;
	logic [COND_W-1:0]   cond;
	logic                sel;

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.vin_pulse = '0;
		idx = PADDR[ADDR_W-1:2];
		hit = 1'b0;
		ro = 1'b0;
		rd = REG_RESET;
		done = PSEL & PENABLE & st.pready;
		cond = DRIVE_COND;
		sel = 1'b0;

		// address decode
		for (int k = 0; k < IN_N; k++) begin
			if (idx == IDX_VIN_FUNC[k]) begin
				hit = 1'b1;
				rd = st.in_func[k];
			end
			if (idx == IDX_VIN_MODE[k]) begin
				hit = 1'b1;
				rd = st.in_mode[k];
			end
		end
		for (int j = 0; j < OUT_N; j++) begin
			if (idx == IDX_VOUT_FUNC[j]) begin
				hit = 1'b1;
				rd = st.out_func[j];
			end
			if (idx == IDX_VOUT_POL[j]) begin
				hit = 1'b1;
				rd = st.out_pol[j];
			end
		end
		if (idx == IDX_VOUT_LEVEL) begin
			hit = 1'b1;
			ro = 1'b1;
			rd = {{(REG_W-OUT_N){1'b0}}, st.vout};
		end
		if (idx == IDX_VIN_VALUE) begin
			hit = 1'b1;
			rd = {{(REG_W-IN_N){1'b0}}, st.vin_value};
		end
		if (PADDR[1:0] != 2'b00) begin
			hit = 1'b0;
		end

		// setup phase: answer is registered for the access phase
		if (PSEL & ~PENABLE) begin
			next_st.pready = 1'b1;
			next_st.pslverr = ~hit | (PWRITE & ro);
			next_st.prdata = (hit & ~PWRITE) ? {{(DATA_W-REG_W){1'b0}}, rd} : '0;
		end

		// write takes effect at the completing edge only
		if (done & PWRITE & ~st.pslverr) begin
			for (int k = 0; k < IN_N; k++) begin
				if (idx == IDX_VIN_FUNC[k]) begin
					next_st.in_func[k] = PWDATA[REG_W-1:0];
				end
				if (idx == IDX_VIN_MODE[k]) begin
					next_st.in_mode[k] = PWDATA[REG_W-1:0];
				end
			end
			for (int j = 0; j < OUT_N; j++) begin
				if (idx == IDX_VOUT_FUNC[j]) begin
					next_st.out_func[j] = PWDATA[REG_W-1:0];
				end
				if (idx == IDX_VOUT_POL[j]) begin
					next_st.out_pol[j] = PWDATA[REG_W-1:0];
				end
			end
			if (idx == IDX_VIN_VALUE) begin
				next_st.vin_value = PWDATA[IN_N-1:0];
				next_st.vin_pulse = PWDATA[IN_N-1:0] & ~st.vin_value;
			end
		end

		// virtual input assertion
		for (int k = 0; k < IN_N; k++) begin
			if (st.in_mode[k] == MODE_EDGE) begin
				next_st.vin_active[k] = next_st.vin_pulse[k];
			end else begin
				next_st.vin_active[k] = next_st.vin_value[k];
			end
		end

		// virtual output selection and polarity
		for (int j = 0; j < OUT_N; j++) begin
			sel = 1'b0;
			if (st.out_func[j] != FUNC_NONE && st.out_func[j] != FUNC_SPARE && st.out_func[j] <= FUNC_LAST) begin
				sel = cond[st.out_func[j][4:0]];
			end
			next_st.vout[j] = sel ^ (st.out_pol[j] == POL_LOW);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA = st.prdata;
	assign PREADY = st.pready;
	assign PSLVERR = st.pslverr;
	assign VIN_ACTIVE = st.vin_active;
	assign VIN_FUNC = st.in_func;
	assign VOUT = st.vout;
endmodule

/* File: vio_checker.sv */
// virtual io port checker
module vio_checker
	import vio_pkg::*;
(
	input logic CLOCK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
	input logic [ADDR_W-1:0] PADDR, input logic [DATA_W-1:0] PWDATA, PRDATA,
	input vio_cond_s DRIVE_COND, input logic [IN_N-1:0] VIN_ACTIVE, input logic [OUT_N-1:0] VOUT
);
	logic [REG_W-1:0] f;
	logic p, m, v;
	wire wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
	wire vw = wr && PADDR == 12'h100;
	wire e = (f < 20 && f != 0 && f != 16 && DRIVE_COND[f[4:0]]) ^ p;
	// shadow of output 0 and input 0 settings
	always_ff @(posedge CLOCK)
		if (!RST_N) {f, p, m, v} <= '0;
		else if (wr) case (PADDR)
			12'h0B0: f <= PWDATA[15:0];
			12'h0B4: p <= PWDATA[15:0] == 1;
			12'h060: m <= PWDATA[15:0] == 1;
			12'h100: v <= PWDATA[0];
		endcase
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	sequence pulse; VIN_ACTIVE[0] ##1 !VIN_ACTIVE[0]; endsequence
	property vo(c); c |=> VOUT[0] == $past(e); endproperty
	in_level_a: assert property (vw && !m |=> VIN_ACTIVE[0] == $past(PWDATA[0])) else $error("level");
	in_edge_a: assert property (vw && m && PWDATA[0] && !v |=> pulse) else $error("pulse");
	out_pol_a: assert property (vo(p)) else $error("pol");
	low_code_a: assert property (vo(f < 5)) else $error("code lo");
	mid_code_a: assert property (vo(f inside {[5:13]})) else $error("code mid");
	high_code_a: assert property (vo(f > 13)) else $error("code hi");
	level_word_a: assert property (PSEL && PENABLE && PREADY && !PWRITE && PADDR == 12'h0AC |->
		PRDATA == {25'h0, $past(VOUT)}) else $error("word");
endmodule
bind vio_top vio_checker u_vio_checker (.*);

/* File: tb_vio_top.sv */
// virtual io bench
module tb_vio_top
	import vio_pkg::*;
;
	timeunit 1ns / 1ns;
	logic CLOCK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, er;
	logic [ADDR_W-1:0] PADDR = 0;
	logic [DATA_W-1:0] PWDATA = 0, PRDATA, rd;
	vio_cond_s DRIVE_COND = 0;
	logic [IN_N-1:0] VIN_ACTIVE;
	logic [IN_N-1:0][REG_W-1:0] VIN_FUNC;
	logic [OUT_N-1:0] VOUT;
	int fails = 0, checks_done = 0, e;
	vio_top u_vio_top (.*);
	initial forever #4 CLOCK = ~CLOCK;
	initial #20000 begin
		fails++;
		complete_run;
	end
	task complete_run;
		$display("%0d checks %0d fails", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(logic [31:0] s, x, string n);
		checks_done++;
		if (s !== x) begin
			fails++;
			$display("wrong value %s exp %h seen %h", n, x, s);
		end
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge CLOCK);
		{PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
		@(posedge CLOCK);
		PENABLE <= 1;
		do @(posedge CLOCK); while (PREADY !== 1);
		{er, rd} = {PSLVERR, PRDATA};
		{PSEL, PENABLE} <= 0;
		#1;
	endtask
	task t_in;
		apb(1, 12'h004, 0);
		chk(er, 1, "unmapped");
		apb(1, 12'h100, 1);
		chk(VIN_ACTIVE[0], 1, "level");
		apb(1, 12'h060, 1);
		apb(1, 12'h100, 0);
		apb(1, 12'h100, 1);
		chk(VIN_ACTIVE[0], 1, "edge");
		@(posedge CLOCK) #1 chk(VIN_ACTIVE[0], 0, "pulse end");
		apb(1, 12'h100, 1);
		chk(VIN_ACTIVE[0], 0, "no edge");
	endtask
	task t_reg;
		apb(1, 12'h05C, 32'h0000_0005);
		chk(er, 0, "func write");
		chk(VIN_FUNC[0], 16'h0005, "func out");
		apb(0, 12'h05C, 0);
		chk(rd, 32'h0000_0005, "func read");
		apb(1, 12'h0AC, 1);
		chk(er, 1, "ro write");
		apb(1, 12'h05D, 0);
		chk(er, 1, "misaligned");
	endtask
	task t_out;
		for (int f = 0; f < 20; f++)
			for (int p = 0; p < 2; p++) begin
				apb(1, 12'h0B0, f);
				apb(1, 12'h0B4, p);
				@(posedge CLOCK) DRIVE_COND <= 20'h1 << f;
				e = (f != 0 && f != 16) ^ p;
				repeat (2) @(posedge CLOCK);
				#1 chk(VOUT[0], e, "output");
				apb(0, 12'h0AC, 0);
				chk(rd, e, "word");
			end
	endtask
	initial begin
		repeat (10) @(posedge CLOCK);
		RST_N <= 1;
		t_in;
		t_reg;
		t_out;
		complete_run;
	end
endmodule
